/* logic/frs_pkg.sv */
/*
 * constants for the ramp sequencer: register numbers, field positions,
 * reset values and state codes.
 * assumes the host delivers whole 32-bit control words, address in bits 4:0.
 */
package frs_pkg;
    // ------------------------------------------------------------
    // register numbers carried in the low bits of each control word
    // ------------------------------------------------------------
    localparam logic [4:0] REG_STATUS_SEL = 5'h03;
    localparam logic [4:0] REG_TEST_BUS   = 5'h04;
    localparam logic [4:0] REG_DIV_MAIN   = 5'h05;
    localparam logic [4:0] REG_FRAC_LSB   = 5'h06;
    localparam logic [4:0] REG_CLOCK_A    = 5'h07;
    localparam logic [4:0] REG_SHAPE      = 5'h0b;
    localparam logic [4:0] REG_CLOCK_B    = 5'h0d;
    localparam logic [4:0] REG_DEVIATION  = 5'h0e;
    localparam logic [4:0] REG_STEP_CNT   = 5'h0f;
    localparam logic [4:0] REG_DELAY      = 5'h10;
    // ------------------------------------------------------------
    // field positions (lsb of each field)
    // ------------------------------------------------------------
    localparam int ADDR_W       = 5;
    localparam int POS_INT      = 17;
    localparam int POS_FRAC_MSB = 5;
    localparam int POS_FRAC_LSB = 5;
    localparam int POS_RAMP_ON  = 29;
    localparam int POS_DIV_A    = 12;
    localparam int POS_DIV_B    = 7;
    localparam int POS_DIV_MODE = 19;
    localparam int POS_CLK_SEL  = 5;
    localparam int POS_HOP      = 5;
    localparam int POS_SHIFT    = 21;
    localparam int POS_SLOPE    = 25;
    localparam int POS_EXT_STEP = 30;
    localparam int POS_STEPS    = 5;
    localparam int POS_DELAY    = 5;
    localparam int POS_SHAPE    = 5;
    localparam int POS_PIN_SEL  = 12;
    localparam int POS_TBUS     = 5;
    // ------------------------------------------------------------
    // widths, codes and reset values
    // ------------------------------------------------------------
    localparam int FRAC_W = 25;
    localparam int INT_W  = 12;
    localparam int ACC_W  = INT_W + FRAC_W;
    localparam logic [1:0]  DIV_MODE_RAMP = 2'h3;
    localparam logic [3:0]  PIN_SEL_RAMP  = 4'hf;
    localparam logic [14:0] TBUS_DONE     = 15'h00c0;
    localparam logic [14:0] TBUS_DOWN     = 15'h0100;
    localparam logic [11:0] DIV_RESET     = 12'h001;
    typedef enum logic [2:0] {
        SHAPE_SINGLE_RAMP = 3'h0,
        SHAPE_SINGLE_TRI  = 3'h1,
        SHAPE_SINGLE_SAW  = 3'h2,
        SHAPE_CONT_SAW    = 3'h3,
        SHAPE_CONT_TRI    = 3'h4
    } frs_shape_t;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DELAY = 2'b01,
        ST_SLOPE = 2'b11,
        ST_DONE  = 2'b10
    } frs_state_t;
endpackage

/* logic/frs_step_timer.sv */
/*
 * step timer: two cascaded dividers, one tick every div_a * div_b cycles.
 * assumes clk_in is the phase-comparison clock; restart_in holds it cleared.
 */
`timescale 1ns/100ps
module frs_step_timer #(
    parameter int W = 12
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         rstn_in,
    // control
    input  wire logic         restart_in,
    input  wire logic [W-1:0] div_a_in,
    input  wire logic [W-1:0] div_b_in,
    // expiry
    output logic              tick_out
);
    import frs_pkg::*;
    typedef struct packed {
        logic [W-1:0] cnt_a;
        logic [W-1:0] cnt_b;
    } frs_tmr_t;
    frs_tmr_t r;
    frs_tmr_t next_r;
    logic     wrap_a;
    logic     wrap_b;

    // a zero divider behaves as one, so the period never collapses to zero
    assign wrap_a   = r.cnt_a + W'(1) >= div_a_in;
    assign wrap_b   = r.cnt_b + W'(1) >= div_b_in;
    assign tick_out = !restart_in && wrap_a && wrap_b;

    // ------------------------------------------------------------
    // divider counters
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        if (restart_in) begin
            next_r = '0;
        end else if (wrap_a) begin
            next_r.cnt_a = '0;
            next_r.cnt_b = wrap_b ? '0 : r.cnt_b + W'(1);
        end else begin
            next_r.cnt_a = r.cnt_a + W'(1);
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // a legal setting keeps ticks apart
    chk_tick_spacing: assert property (@(posedge clk_in) disable iff (!rstn_in)
        tick_out && !restart_in && (div_a_in > W'(1) || div_b_in > W'(1)) |=> !tick_out)
        else $error("step timer ticked on two cycles in a row");
endmodule

/* logic/frs_sequencer.sv */
/*
 * ramp sequencer: holds the ramp control words and steps the divide word
 * through up to four delay and slope sections.
 * assumes a serial front end delivers each 32-bit control word with a
 * one-cycle strobe, and clk_in is the phase-comparison clock.
 */
`timescale 1ns/100ps
module frs_sequencer #(
    parameter int DIV_W   = 12,
    parameter int HOP_W   = 16,
    parameter int STEP_W  = 20,
    parameter int DELAY_W = 12
) (
    // clock and reset
    input  wire logic                        clk_in,
    input  wire logic                        rstn_in,
    // control words from the serial front end
    input  wire logic                        word_strobe_in,
    input  wire logic [31:0]                 word_in,
    // external step pin
    input  wire logic                        ext_step_pin_in,
    // divide word to the synthesizer
    output logic [frs_pkg::INT_W-1:0]        div_int_out,
    output logic [frs_pkg::FRAC_W-1:0]       div_frac_out,
    // status
    output logic                             shared_status_pin_out,
    output logic                             ramp_busy_out,
    output logic [1:0]                       section_out
);
    import frs_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [INT_W-1:0]                int_word;
        logic [11:0]                     frac_msb;
        logic [12:0]                     frac_lsb;
        logic                            ramp_on;
        logic [DIV_W-1:0]                div_a;
        logic [1:0]                      div_mode;
        logic [3:0][DIV_W-1:0]           div_b;
        logic [3:0][HOP_W-1:0]           hop;
        logic [3:0][3:0]                 shift;
        logic                            ext_step;
        logic [3:0][STEP_W-1:0]          steps;
        logic [3:0][DELAY_W-1:0]         delay;
        logic [2:0]                      shape;
        logic [3:0]                      pin_sel;
        logic [14:0]                     tbus;
        frs_state_t                      st;
        logic [1:0]                      sec;
        logic [ACC_W-1:0]                acc;
        logic [STEP_W-1:0]               steps_left;
        logic [DELAY_W-1:0]              delay_left;
        logic                            ext_prev;
        logic                            complete;
        logic                            status;
    } frs_seq_t;
    frs_seq_t r;
    frs_seq_t next_r;

    logic [ACC_W-1:0] start_word;
    logic [ACC_W-1:0] hop_scaled;
    logic             ramp_run;
    logic             timer_tick;
    logic             step_ev;
    logic             sel_done;
    logic             sel_down;
    logic [1:0]       wsel;
    logic [4:0]       waddr;

    // ------------------------------------------------------------
    // derived terms
    // ------------------------------------------------------------
    assign start_word = {r.int_word, r.frac_msb, r.frac_lsb};
    // sign extend then shift; a 16-bit word shifted by 15 still fits
    assign hop_scaled = ACC_W'($signed({{(ACC_W-HOP_W){r.hop[r.sec][HOP_W-1]}}, r.hop[r.sec]})
                        <<< r.shift[r.sec]);
    assign ramp_run   = r.ramp_on && r.div_mode == DIV_MODE_RAMP;
    // the pin is taken as synchronous, so a plain edge detector suffices
    assign step_ev    = r.ext_step ? (ext_step_pin_in && !r.ext_prev) : timer_tick;
    assign sel_done   = r.pin_sel == PIN_SEL_RAMP && r.tbus == TBUS_DONE;
    assign sel_down   = r.pin_sel == PIN_SEL_RAMP && r.tbus == TBUS_DOWN;
    assign wsel       = word_in[POS_SLOPE +: 2];
    assign waddr      = word_in[ADDR_W-1:0];

    // divider a is shared, divider b follows the current slope
    frs_step_timer #(
        .W (DIV_W)
    ) u_timer (
        .clk_in     (clk_in),
        .rstn_in    (rstn_in),
        .restart_in (!ramp_run || r.st == ST_IDLE || r.st == ST_DONE),
        .div_a_in   (r.div_a),
        .div_b_in   (r.div_b[r.sec]),
        .tick_out   (timer_tick)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic end_sec;
        end_sec = 1'b0;
        next_r = r;
        next_r.ext_prev = ext_step_pin_in;
        next_r.complete = 1'b0;
        // control word decode; writes land mid-ramp without restarting it
        if (word_strobe_in) begin
            unique case (waddr)
                REG_STATUS_SEL: next_r.pin_sel = word_in[POS_PIN_SEL +: 4];
                REG_TEST_BUS:   next_r.tbus = word_in[POS_TBUS +: 15];
                REG_DIV_MAIN: begin
                    next_r.int_word = word_in[POS_INT +: INT_W];
                    next_r.frac_msb = word_in[POS_FRAC_MSB +: 12];
                    next_r.ramp_on  = word_in[POS_RAMP_ON];
                end
                REG_FRAC_LSB:   next_r.frac_lsb = word_in[POS_FRAC_LSB +: 13];
                REG_CLOCK_A:    next_r.div_a = word_in[POS_DIV_A +: DIV_W];
                REG_SHAPE:      next_r.shape = word_in[POS_SHAPE +: 3];
                REG_CLOCK_B: begin
                    next_r.div_mode = word_in[POS_DIV_MODE +: 2];
                    next_r.div_b[word_in[POS_CLK_SEL +: 2]] = word_in[POS_DIV_B +: DIV_W];
                end
                REG_DEVIATION: begin
                    next_r.hop[wsel]   = word_in[POS_HOP +: HOP_W];
                    next_r.shift[wsel] = word_in[POS_SHIFT +: 4];
                    next_r.ext_step    = word_in[POS_EXT_STEP];
                end
                REG_STEP_CNT:   next_r.steps[wsel] = word_in[POS_STEPS +: STEP_W];
                REG_DELAY:      next_r.delay[wsel] = word_in[POS_DELAY +: DELAY_W];
                default: ;
            endcase
        end
        // sequencing
        if (!ramp_run) begin
            next_r.st  = ST_IDLE;
            next_r.sec = 2'h0;
            next_r.acc = start_word;
        end else begin
            unique case (r.st)
                ST_IDLE: begin
                    next_r.acc        = start_word;
                    next_r.sec        = 2'h0;
                    next_r.delay_left = r.delay[0];
                    next_r.st         = ST_DELAY;
                end
                ST_DELAY: begin
                    if (r.delay_left == '0) begin
                        next_r.steps_left = r.steps[r.sec];
                        next_r.st         = ST_SLOPE;
                    end else if (step_ev) begin
                        next_r.delay_left = r.delay_left - DELAY_W'(1);
                    end
                end
                ST_SLOPE: begin
                    // the section ends once the count is spent, one cycle after the last hop,
                    // so a sawtooth return cannot swallow the final step
                    if (r.steps_left == '0) begin
                        end_sec = 1'b1;
                    end else if (step_ev) begin
                        next_r.acc        = r.acc + hop_scaled;
                        next_r.steps_left = r.steps_left - STEP_W'(1);
                    end
                end
                ST_DONE: ;
            endcase
            if (end_sec) begin
                if (r.sec == 2'h3 || r.shape == SHAPE_SINGLE_RAMP) begin
                    next_r.complete = 1'b1;
                    next_r.sec      = 2'h0;
                    unique case (r.shape)
                        SHAPE_CONT_SAW: begin
                            next_r.acc        = start_word;
                            next_r.delay_left = r.delay[0];
                            next_r.st         = ST_DELAY;
                        end
                        SHAPE_CONT_TRI: begin
                            next_r.delay_left = r.delay[0];
                            next_r.st         = ST_DELAY;
                        end
                        SHAPE_SINGLE_SAW: begin
                            next_r.acc = start_word;
                            next_r.st  = ST_DONE;
                        end
                        default: next_r.st = ST_DONE;
                    endcase
                end else begin
                    next_r.sec        = r.sec + 2'h1;
                    next_r.delay_left = r.delay[r.sec + 2'h1];
                    next_r.st         = ST_DELAY;
                end
            end
        end
        // status pin lags the event by one cycle
        next_r.status = (sel_done && r.complete) ||
                        (sel_down && r.st == ST_SLOPE && r.hop[r.sec][HOP_W-1]);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            r       <= '0;
            r.div_a <= DIV_RESET;
            r.div_b <= {4{DIV_RESET}};
        end else begin
            r <= next_r;
        end
    end

    // outputs come straight from flip-flops, except ramp_busy_out, which is decoded from the state
    assign div_int_out           = r.acc[ACC_W-1 -: INT_W];
    assign div_frac_out          = r.acc[FRAC_W-1:0];
    assign shared_status_pin_out = r.status;
    assign ramp_busy_out         = r.st == ST_DELAY || r.st == ST_SLOPE;
    assign section_out           = r.sec;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    chk_idle_holds: assert property (!ramp_run |=> r.acc == $past(start_word))
        else $error("divide word moved while ramp disabled");
    chk_step_adds: assert property (ramp_run && r.st == ST_SLOPE && step_ev && r.steps_left != '0
        |=> r.acc == $past(r.acc) + $past(hop_scaled))
        else $error("step did not add scaled hop");
    chk_delay_still: assert property (ramp_run && r.st == ST_DELAY |=> $stable(r.acc))
        else $error("divide word moved during delay");
    chk_count_dec: assert property (ramp_run && r.st == ST_SLOPE && step_ev && r.steps_left > STEP_W'(1)
        |=> r.steps_left == $past(r.steps_left) - STEP_W'(1) && r.st == ST_SLOPE)
        else $error("step count not decremented");
    chk_ext_bypass: assert property (r.ext_step && !(ext_step_pin_in && !r.ext_prev) && ramp_run
        && r.st == ST_SLOPE && r.steps_left != '0 |=> $stable(r.acc))
        else $error("step taken without a pin pulse");
    chk_done_pin: assert property (sel_done && r.complete ##1 1'b1 |-> shared_status_pin_out)
        else $error("ramp complete missing on status pin");
    chk_down_pin: assert property (sel_down && r.st == ST_SLOPE && r.hop[r.sec][HOP_W-1]
        |=> shared_status_pin_out)
        else $error("ramp down missing on status pin");
    chk_section_walk: assert property (ramp_run && r.st == ST_SLOPE && r.sec != 2'h3 && r.steps_left == '0
        && r.shape != SHAPE_SINGLE_RAMP |=> r.sec == $past(r.sec) + 2'h1 && r.st == ST_DELAY)
        else $error("section did not advance");
    chk_mode_gate: assert property (r.div_mode != DIV_MODE_RAMP |=> r.st == ST_IDLE)
        else $error("ramp ran without ramp divider mode");

    cov_complete: cover property (r.complete);
    cov_ext_step: cover property (r.ext_step && step_ev && r.st == ST_SLOPE);
    cov_cont_wrap: cover property (r.complete && r.st == ST_DELAY);
    cov_last_sec: cover property (r.sec == 2'h3 && r.st == ST_SLOPE);
endmodule

/* tb/frs_host_model.sv */
/*
 * far-side host model: hands the sequencer one control word at a time
 * and pulses the external step pin.
 * assumes the sequencer takes a word on any clock edge with the strobe high.
 */
`timescale 1ns/100ps
module frs_host_model (
    // clock
    input  wire logic        clk_in,
    // control words and step pin
    output logic             word_strobe_out,
    output logic [31:0]      word_out,
    output logic             step_pin_out
);
    // ------------------------------------------------------------
    // word delivery
    // ------------------------------------------------------------
    // idle word lines carry the inverse of the last word, never a stale copy
    initial begin
        word_strobe_out = 1'b0;
        word_out        = 32'h0;
        step_pin_out    = 1'b0;
    end
    task automatic send(input logic [31:0] w);
        @(posedge clk_in);
        word_strobe_out <= 1'b1;
        word_out        <= w;
        @(posedge clk_in);
        word_strobe_out <= 1'b0;
        word_out        <= ~w;
    endtask
    // two cycles high then two low, so each pulse is one clean rising edge
    task automatic pulse();
        @(posedge clk_in);
        step_pin_out <= 1'b1;
        repeat (2) @(posedge clk_in);
        step_pin_out <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask
    function automatic logic [31:0] r5_word(input logic [11:0] w, input logic [24:0] f, input logic on);
        return {2'b00, on, w, f[24:13], 5'h05};
    endfunction
    task automatic set_word(input logic [11:0] w, input logic [24:0] f, input logic on);
        send({14'h0, f[12:0], 5'h06});
        send(r5_word(w, f, on));
    endtask
    // slopes written 3 down to 0, each register once per slope, enable last
    task automatic program_ramp(input logic [2:0] shape, input logic ext, input logic [11:0] div_a,
                                input logic [11:0] div_b [4], input logic [15:0] hop [4],
                                input logic [3:0] shift [4], input logic [19:0] steps [4],
                                input logic [11:0] dly [4], input logic [36:0] start);
        logic [1:0] sel;
        for (int k = 3; k >= 0; k--) begin
            sel = 2'(k);
            send({5'h0, sel, 8'h0, dly[k], 5'h10});
            send({5'h0, sel, steps[k], 5'h0f});
            send({1'b0, ext, 3'h0, sel, shift[k], hop[k], 5'h0e});
            send({11'h0, 2'b11, div_b[k], sel, 5'h0d});
        end
        send({24'h0, shape, 5'h0b});
        send({8'h0, div_a, 7'h0, 5'h07});
        set_word(start[36:25], start[24:0], 1'b1);
    endtask
endmodule

/* tb/testbench.sv */
/*
 * testbench: loads start words, runs every ramp shape from the timer, runs the single
 * ramp and single triangle from the step pin, and checks the status pin routing.
 * assumes frs_host_model as the far side and one 200 MHz clock.
 */
`timescale 1ns/100ps
module testbench;
    import frs_pkg::*;
    // ------------------------------------------------------------
    // signals and bench state
    // ------------------------------------------------------------
    localparam int TIMEOUT = 20000;
    logic                  clk_in;
    logic                  rstn_in;
    logic                  word_strobe;
    logic [31:0]           word;
    logic                  step_pin;
    logic [INT_W-1:0]      div_int;
    logic [FRAC_W-1:0]     div_frac;
    logic                  status_pin;
    logic                  busy;
    logic [1:0]            section;
    int                    miscompares = 0;
    int                    tests_run = 0;
    int                    cyc = 0;
    int                    last_chg = 0;
    int                    stat_cnt = 0;
    int                    gap_exp;
    bit                    free_run = 0;
    bit                    tbus_down = 0;
    logic [ACC_W-1:0]      exp_q[$];
    int                    gap_q[$];
    logic [ACC_W-1:0]      cur_exp = '0;
    logic [ACC_W-1:0]      prev_word = '0;
    logic [ACC_W-1:0]      start_w;
    logic [11:0]           div_b [4];
    logic [15:0]           hop [4];
    logic [3:0]            shift [4];
    logic [19:0]           steps [4];
    logic [11:0]           dly [4];
    // 5 ns clock
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    frs_host_model host (.clk_in(clk_in), .word_strobe_out(word_strobe), .word_out(word), .step_pin_out(step_pin));
    frs_sequencer dut (.clk_in(clk_in), .rstn_in(rstn_in), .word_strobe_in(word_strobe), .word_in(word),
                       .ext_step_pin_in(step_pin), .div_int_out(div_int), .div_frac_out(div_frac),
                       .shared_status_pin_out(status_pin), .ramp_busy_out(busy), .section_out(section));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (miscompares == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // only real changes of the divide word are noted, matching what the monitor sees
    function automatic void push_exp(input logic [ACC_W-1:0] v, input int gap);
        if (v !== cur_exp) begin
            exp_q.push_back(v);
            gap_q.push_back(gap);
            cur_exp = v;
        end
    endfunction
    task automatic wait_busy(input logic level, input int bound);
        for (int n = 0; n < bound && busy !== level; n++) @(negedge clk_in);
        check(busy, level);
    endtask
    task automatic load_start(input logic [11:0] w, input logic [24:0] f);
        push_exp({cur_exp[36:13], f[12:0]}, 0);
        push_exp({w, f}, 0);
        start_w = {w, f};
        host.set_word(w, f, 1'b0);
    endtask
    // sgn0 of 0 or 1 forces the sign of the first slope, 2 leaves it random
    task automatic run_ramp(input logic [2:0] shape, input logic ext, input int sgn0);
        logic [ACC_W-1:0] acc;
        int               pulses;
        int               stat0;
        acc    = start_w;
        pulses = 0;
        // small hops and counts keep the whole value well inside its allowed swing
        for (int k = 0; k < 4; k++) begin
            div_b[k] = 12'($urandom_range(1, 3));
            shift[k] = 4'($urandom_range(0, 15));
            steps[k] = 20'($urandom_range(1, 4));
            dly[k]   = 12'($urandom_range(0, 2));
            hop[k]   = 16'($urandom_range(1, 255));
            if ((k == 0 && sgn0 < 2) ? sgn0 == 1 : $urandom_range(0, 1) == 1) hop[k] = -hop[k];
        end
        for (int k = 0; k < ((shape == SHAPE_SINGLE_RAMP) ? 1 : 4); k++) begin
            pulses += int'(steps[k]) + int'(dly[k]);
            for (int i = 1; i <= int'(steps[k]); i++) begin
                acc = acc + ({{21{hop[k][15]}}, hop[k]} << shift[k]);
                push_exp(acc, (i > 1 && !ext) ? 2 * int'(div_b[k]) : 0);
            end
        end
        if (shape == SHAPE_SINGLE_SAW || shape == SHAPE_CONT_SAW) push_exp(start_w, 0);
        stat0 = stat_cnt;
        host.program_ramp(shape, ext, 12'h002, div_b, hop, shift, steps, dly, start_w);
        wait_busy(1'b1, 50);
        if (ext) repeat (pulses) host.pulse();
        if (shape <= SHAPE_SINGLE_SAW) begin
            wait_busy(1'b0, 4000);
            repeat (4) @(negedge clk_in);
            check(exp_q.size(), 0);
            if (tbus_down) check(stat_cnt != stat0, hop[0][15]);
            else check(stat_cnt - stat0, 1);
            push_exp(start_w, 0);
            host.send(host.r5_word(start_w[36:25], start_w[24:0], 1'b0));
        end else begin
            for (int n = 0; n < 4000 && exp_q.size() != 0; n++) @(negedge clk_in);
            free_run = 1'b1;
            check(busy, 1'b1);
            host.send(host.r5_word(start_w[36:25], start_w[24:0], 1'b0));
            repeat (4) @(negedge clk_in);
            check({div_int, div_frac}, start_w);
            check(exp_q.size(), 0);
            cur_exp  = start_w;
            free_run = 1'b0;
        end
    endtask
    // ------------------------------------------------------------
    // monitor: every change of the divide word outside free_run takes the oldest note
    // ------------------------------------------------------------
    always @(posedge clk_in) begin
        cyc++;
        if (status_pin === 1'b1) stat_cnt++;
        if (rstn_in === 1'b1 && {div_int, div_frac} !== prev_word && !free_run) begin
            if (exp_q.size() == 0) begin
                check({div_int, div_frac}, prev_word);
            end else begin
                gap_exp = gap_q.pop_front();
                check({div_int, div_frac}, exp_q.pop_front());
                if (gap_exp != 0) check(cyc - last_chg, gap_exp);
            end
        end
        if ({div_int, div_frac} !== prev_word) last_chg = cyc;
        prev_word = {div_int, div_frac};
        if (cyc >= TIMEOUT) begin
            miscompares++;
            finish_test();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hcdc1));
        rstn_in = 1'b0;
        repeat (8) @(posedge clk_in);
        check({div_int, div_frac, status_pin, busy, section}, '0);
        rstn_in <= 1'b1;
        host.send({16'h0, PIN_SEL_RAMP, 7'h0, REG_STATUS_SEL});
        host.send({12'h0, TBUS_DONE, REG_TEST_BUS});
        repeat (3) load_start(12'($urandom_range(100, 3000)), 25'($urandom));
        check(busy, 1'b0);
        for (int s = 0; s < 5; s++) run_ramp(3'(s), 1'b0, 2);
        run_ramp(SHAPE_SINGLE_RAMP, 1'b1, 2);
        run_ramp(SHAPE_SINGLE_TRI, 1'b1, 2);
        // ramp down on the status pin, once rising and once falling
        host.send({12'h0, TBUS_DOWN, REG_TEST_BUS});
        tbus_down = 1'b1;
        for (int s = 0; s < 2; s++) run_ramp(SHAPE_SINGLE_RAMP, 1'b0, s);
        finish_test();
    end
endmodule
